// *** hw/epv_prio_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Shared constants and types
package epv_pkg;
  localparam int          NUM_IRQ      = 44;
  localparam int          NUM_EXC      = 16 + NUM_IRQ;
  localparam int          EXC_W        = 6;
  localparam int          PRI_W        = 3;
  localparam int          LVL_W        = 4;
  localparam logic [5:0]  EXC_NMI      = 6'h02;
  localparam logic [5:0]  EXC_HARD     = 6'h03;
  localparam logic [5:0]  EXC_MEM      = 6'h04;
  localparam logic [5:0]  EXC_USAGE    = 6'h06;
  localparam logic [5:0]  EXC_PENDABLE_SERVICE_REQUEST   = 6'h0E;
  localparam logic [5:0]  EXC_SYSTICK  = 6'h0F;
  localparam logic [5:0]  EXC_IRQ0     = 6'h10;
  localparam logic [5:0]  EXC_LAST     = 6'h3B;
  localparam logic [15:0] SYS_VALID    = 16'hD87C;
  localparam logic [15:0] SYS_EXC_MASK = 16'hD87C;
  // Urgency levels, smaller is more urgent
  localparam logic [3:0]  LVL_RESET    = 4'h0;
  localparam logic [3:0]  LVL_NMI      = 4'h1;
  localparam logic [3:0]  LVL_HARD     = 4'h2;
  localparam logic [3:0]  LVL_CFG0     = 4'h3;
  localparam logic [3:0]  LVL_IDLE     = 4'hF;
  localparam logic [2:0]  PRI_RESET    = 3'h0;
  localparam logic [31:0] VTOR_RESET   = 32'h0000_0000;
  localparam logic [31:0] VTOR_MIN     = 32'h0000_0100;
  localparam logic [31:0] VTOR_MAX     = 32'h3FFF_FF00;
  localparam int          VTOR_ALIGN   = 8;
  localparam int          VEC_SHIFT    = 2;

  typedef struct packed {
    logic             vld;
    logic [EXC_W-1:0] num;
    logic [PRI_W-1:0] val;
  } epv_pri_wr_t;

  typedef struct packed {
    logic        vld;
    logic        priv;
    logic [31:0] base;
  } epv_vtor_wr_t;

  typedef struct packed {
    logic             vld;
    logic [EXC_W-1:0] num;
    logic [31:0]      addr;
    logic             is_fault;
    logic             is_sys;
  } epv_entry_t;
endpackage

// ============================================================
// Most urgent request, lowest index wins a tie
module epv_prio_pick #(
  parameter int N  = 60,
  parameter int LW = 4,
  parameter int IW = 6
) (
  input  wire logic [N-1:0]         i_req,
  input  wire logic [N-1:0][LW-1:0] i_lvl,
  output logic                      o_vld,
  output logic [IW-1:0]             o_idx,
  output logic [LW-1:0]             o_lvl
);
  // Strict compare keeps the first (lowest) index on equal levels
  always_comb begin
    o_vld = 1'b0;
    o_idx = '0;
    o_lvl = '1;
    for (int k = 0; k < N; k++) begin
      if (i_req[k] && (!o_vld || (i_lvl[k] < o_lvl))) begin
        o_vld = 1'b1;
        o_idx = IW'(k);
        o_lvl = i_lvl[k];
      end
    end
  end
endmodule

`default_nettype wire

// *** hw/epv_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module epv_core
  import epv_pkg::*;
#(
  parameter int N_IRQ = epv_pkg::NUM_IRQ
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  input  wire logic [N_IRQ-1:0]      i_irq,
  input  wire logic [15:0]           i_sys_pend,
  input  wire epv_pkg::epv_pri_wr_t  i_pri_wr,
  input  wire epv_pkg::epv_vtor_wr_t i_vtor_wr,
  input  wire logic                  i_ack,
  input  wire logic [5:0]            i_ack_num,
  input  wire logic                  i_ret,
  input  wire logic [5:0]            i_ret_num,
  output epv_pkg::epv_entry_t        o_entry,
  output logic [31:0]                o_vtor,
  output logic [3:0]                 o_act_lvl
);
  import epv_pkg::*;

  localparam int NE = 16 + N_IRQ;

  // ==========================================================
  // Signals
  logic [N_IRQ-1:0]           irq_s1_r;
  logic [N_IRQ-1:0]           irq_s2_r;
  logic [NE-1:0]              pend_r;
  logic [NE-1:0]              act_r;
  logic [NE-1:0]              pend_set;
  logic [NE-1:0][PRI_W-1:0]   pri_r;
  logic [NE-1:0][LVL_W-1:0]   lvl;
  logic [31:0]                vtor_r;
  logic                       best_vld;
  logic [EXC_W-1:0]           best_num;
  logic [LVL_W-1:0]           best_lvl;
  logic                       act_vld;
  logic [LVL_W-1:0]           act_min;
  logic [LVL_W-1:0]           act_lvl;
  logic                       take;
  logic                       vtor_ok;
  epv_entry_t                 entry_nxt;

  // ==========================================================
  // Peripheral lines pass two flip-flops
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
    end else begin
      irq_s1_r <= i_irq;
      irq_s2_r <= irq_s1_r;
    end
  end

  // ==========================================================
  // Per exception: pending, active, priority, level
  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_exc
      localparam bit IS_SYS = (g < 16) ? SYS_VALID[g % 16] : 1'b1;
      localparam bit FIXED  = (g == EXC_NMI) || (g == EXC_HARD);
      // IRQ n is exception 16+n; system pends pass only where SYS_VALID is set
      if (g >= 16) begin : g_irq
        assign pend_set[g] = irq_s2_r[g-16];
      end else begin : g_sys
        assign pend_set[g] = IS_SYS & i_sys_pend[g];
      end
      // Fixed levels sit below every programmable one
      assign lvl[g] = (g == EXC_NMI)  ? LVL_NMI  :
                      (g == EXC_HARD) ? LVL_HARD :
                      LVL_CFG0 + LVL_W'(pri_r[g]);

      // Set wins over the acknowledge clear
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pend_r[g] <= 1'b0;
          act_r[g]  <= 1'b0;
          pri_r[g]  <= PRI_RESET;
        end else begin
          pend_r[g] <= pend_set[g] |
                       (pend_r[g] & ~(i_ack && i_ack_num == g));
          act_r[g]  <= (act_r[g] & ~(i_ret && i_ret_num == g)) |
                       (i_ack && i_ack_num == g);
          if (i_pri_wr.vld && i_pri_wr.num == g && IS_SYS && !FIXED)
            pri_r[g] <= i_pri_wr.val;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pending winner and running handler level
  epv_prio_pick #(.N(NE), .LW(LVL_W), .IW(EXC_W)) u_pend_pick (
    .i_req (pend_r),
    .i_lvl (lvl),
    .o_vld (best_vld),
    .o_idx (best_num),
    .o_lvl (best_lvl)
  );

  epv_prio_pick #(.N(NE), .LW(LVL_W), .IW(EXC_W)) u_act_pick (
    .i_req (act_r),
    .i_lvl (lvl),
    .o_vld (act_vld),
    .o_idx (),
    .o_lvl (act_min)
  );

  // ==========================================================
  // Entry decision and vector address
  assign act_lvl = act_vld ? act_min : LVL_IDLE;
  assign take    = best_vld && (best_lvl < act_lvl);
  assign entry_nxt.vld      = take && !i_ack;
  assign entry_nxt.num      = best_num;
  assign entry_nxt.addr     = vtor_r +
                              {24'h00_0000, best_num, 2'h0};
  assign entry_nxt.is_fault = best_num >= EXC_HARD &&
                              best_num <= EXC_USAGE;
  assign entry_nxt.is_sys   = best_num < EXC_IRQ0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_entry <= '0;
    end else begin
      o_entry <= entry_nxt;
    end
  end

  // ==========================================================
  // Table base: reset to zero, privileged in-range writes only
  assign vtor_ok = i_vtor_wr.vld && i_vtor_wr.priv &&
                   i_vtor_wr.base >= VTOR_MIN &&
                   i_vtor_wr.base <= VTOR_MAX;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vtor_r <= VTOR_RESET;
    end else if (vtor_ok) begin
      vtor_r <= {i_vtor_wr.base[31:VTOR_ALIGN], 8'h00};
    end
  end

  assign o_vtor    = vtor_r;
  assign o_act_lvl = act_lvl;

  // ==========================================================
  // Checks
  logic any_pri_wr_r;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      any_pri_wr_r <= 1'b0;
    end else if (i_pri_wr.vld) begin
      any_pri_wr_r <= 1'b1;
    end
  end

  last_irq_vec_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    o_entry.vld && o_entry.num == EXC_LAST |->
      o_entry.addr == $past(vtor_r) + 32'h0000_00EC)
    else $error("last irq vector offset wrong");

  pendable_service_request_vec_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    o_entry.vld && o_entry.num == EXC_PENDABLE_SERVICE_REQUEST |->
      o_entry.addr == $past(vtor_r) + 32'h0000_0038)
    else $error("pendable service vector offset wrong");

  prio_reset_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    !any_pri_wr_r |-> lvl[EXC_IRQ0] == LVL_CFG0 &&
                      lvl[EXC_SYSTICK] == LVL_CFG0)
    else $error("programmable priority not zero after reset");

  vtor_range_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    vtor_r == VTOR_RESET ||
    (vtor_r >= VTOR_MIN && vtor_r <= VTOR_MAX && vtor_r[7:0] == 8'h00))
    else $error("table base outside allowed range");

  tie_low_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    pend_r[16] && pend_r[17] && pri_r[16] == pri_r[17] && take
      && !i_ack |=> o_entry.num != 6'h11)
    else $error("tie not resolved to lowest number");

  no_eq_preempt_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    o_entry.vld |-> $past(best_lvl) < $past(act_lvl))
    else $error("entry without strictly higher urgency");

  nmi_first_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    pend_r[2] && act_lvl > LVL_NMI && !i_ack |=>
      o_entry.vld && o_entry.num == EXC_NMI)
    else $error("pending NMI not presented");

  fault_class_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    o_entry.vld |-> o_entry.is_fault ==
      (o_entry.num inside {[3:6]}))
    else $error("fault class flag wrong");

  vec_addr_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    o_entry.vld && !$past(vtor_ok) |->
      o_entry.addr == vtor_r + {24'h00_0000, o_entry.num, 2'h0})
    else $error("vector address not base plus four times number");

  irq_entry_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rstn) o_entry.vld && !o_entry.is_sys);
  preempt_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rstn) o_entry.vld && act_vld);
  relocate_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rstn) vtor_ok);
  eq_pend_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rstn) best_vld && act_vld && best_lvl == act_lvl);
endmodule

`default_nettype wire

// *** testbench/epv_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Core entry side: takes each offered entry when allowed
module epv_core_model
  import epv_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_rstn,
  input  wire epv_pkg::epv_entry_t i_entry,
  input  wire logic                i_ack_en,
  output logic                     o_ack,
  output logic [5:0]               o_ack_num,
  output logic [31:0]              o_handler
);
  // Table image: stack word first, then one handler per vector
  logic [31:0] vec_tbl [0:63];
  initial begin
    vec_tbl[0] = 32'h2000_0400;
    for (int k = 1; k < 64; k++)
      vec_tbl[k] = 32'h0000_4001 + 32'(k) * 32'h0000_0100;
  end

  // Handler word at the offered vector address
  assign o_handler = vec_tbl[i_entry.addr[7:2]];

  // One ack pulse per offer, never two in a row
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack     <= 1'b0;
      o_ack_num <= 6'h00;
    end else begin
      o_ack     <= i_entry.vld && i_ack_en && !o_ack;
      o_ack_num <= i_entry.num;
    end
  end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bench for the exception priority and vector block
module tb_top;
  import epv_pkg::*;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic [43:0]  irq = 44'h0;
  logic [15:0]  sp = 16'h0000;
  epv_pri_wr_t  pw = '0;
  epv_vtor_wr_t vw = '0;
  logic         ack_en = 1'b0;
  logic         ret = 1'b0;
  logic [5:0]   ret_num = 6'h00;
  logic         ack;
  logic [5:0]   ack_num;
  epv_entry_t   ent;
  logic [31:0]  hnd;
  logic [31:0]  vtor;
  logic [3:0]   act;
  int           n_errors = 0;
  int           cmp_count = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  epv_core u_epv_core (.i_core_clk(clk), .i_rstn(rstn), .i_irq(irq),
    .i_sys_pend(sp), .i_pri_wr(pw), .i_vtor_wr(vw), .i_ack(ack),
    .i_ack_num(ack_num), .i_ret(ret), .i_ret_num(ret_num),
    .o_entry(ent), .o_vtor(vtor), .o_act_lvl(act));

  epv_core_model u_epv_core_model (.i_core_clk(clk), .i_rstn(rstn),
    .i_entry(ent), .i_ack_en(ack_en), .o_ack(ack), .o_ack_num(ack_num),
    .o_handler(hnd));

  // ============================================================
  // Shared tasks
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  task do_reset;
    @(posedge clk);
    rstn   <= 1'b0;
    ack_en <= 1'b0;
    irq    <= 44'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    idle(1);
  endtask

  task wait_ent(input logic [5:0] n, input logic [31:0] a, input logic s);
    int k;
    for (k = 0; k < 12; k++) begin
      @(negedge clk);
      if (ent.vld === 1'b1)
        break;
    end
    if (ent.vld !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED entry valid exp 1 got 0");
      end_of_test;
    end else begin
      chk("entry num", {26'h0, n}, {26'h0, ent.num});
      chk("entry addr", a, ent.addr);
      chk("entry sys", {31'h0, s}, {31'h0, ent.is_sys});
      chk("handler", 32'h0000_4001 + {18'h0, n, 8'h00}, hnd);
    end
  endtask

  task psys(input logic [15:0] m);
    @(posedge clk);
    sp <= m;
    @(posedge clk);
    sp <= 16'h0000;
  endtask

  task wpri(input logic [5:0] n, input logic [2:0] v);
    @(posedge clk);
    pw <= '{vld: 1'b1, num: n, val: v};
    @(posedge clk);
    pw.vld <= 1'b0;
  endtask

  task wvt(input logic p, input logic [31:0] b);
    @(posedge clk);
    vw <= '{vld: 1'b1, priv: p, base: b};
    @(posedge clk);
    vw.vld <= 1'b0;
  endtask

  task rt(input logic [5:0] n);
    idle(3);
    @(posedge clk);
    ret     <= 1'b1;
    ret_num <= n;
    @(posedge clk);
    ret <= 1'b0;
  endtask

  // ============================================================
  // Scenarios
  task t_vec;
    chk("reset vtor", 32'h0, vtor);
    chk("reset act", 32'hF, {28'h0, act});
    chk("reset vld", 32'h0, {31'h0, ent.vld});
    ack_en <= 1'b1;
    psys(16'h4000);
    wait_ent(6'h0E, 32'h38, 1'b1);
    idle(4);
    chk("act lvl", 32'h3, {28'h0, act});
    rt(6'h0E);
    psys(16'h8000);
    wait_ent(6'h0F, 32'h3C, 1'b1);
  endtask

  task t_irq;
    @(posedge clk);
    irq[43] <= 1'b1;
    wait_ent(6'h3B, 32'hEC, 1'b0);
    @(posedge clk);
    irq[1:0] <= 2'b11;
    irq[43]  <= 1'b0;
    idle(5);
    wait_ent(6'h10, 32'h40, 1'b0);
  endtask

  task t_tie;
    ack_en <= 1'b1;
    psys(16'hC000);
    wait_ent(6'h0E, 32'h38, 1'b1);
    rt(6'h0E);
    wait_ent(6'h0F, 32'h3C, 1'b1);
    rt(6'h0F);
    wpri(6'h0E, 3'h3);
    wpri(6'h0F, 3'h1);
    psys(16'hC000);
    wait_ent(6'h0F, 32'h3C, 1'b1);
  endtask

  task t_pre;
    ack_en <= 1'b1;
    wpri(6'h0E, 3'h2);
    psys(16'h4000);
    wait_ent(6'h0E, 32'h38, 1'b1);
    idle(4);
    chk("act lvl", 32'h5, {28'h0, act});
    ack_en <= 1'b0;
    wpri(6'h0F, 3'h2);
    psys(16'h8000);
    idle(6);
    chk("equal no entry", 32'h0, {31'h0, ent.vld});
    wpri(6'h03, 3'h7);
    psys(16'h0008);
    wait_ent(6'h03, 32'h0C, 1'b1);
    chk("fault flag", 32'h1, {31'h0, ent.is_fault});
    ack_en <= 1'b1;
    rt(6'h03);
    rt(6'h0E);
    wait_ent(6'h0F, 32'h3C, 1'b1);
  endtask

  task t_vtor;
    wvt(1'b1, 32'h2000_0000);
    idle(1);
    chk("vtor", 32'h2000_0000, vtor);
    wvt(1'b0, 32'h1000_0000);
    wvt(1'b1, 32'h4000_0000);
    wvt(1'b1, 32'h0000_0080);
    idle(1);
    chk("vtor kept", 32'h2000_0000, vtor);
    psys(16'h0004);
    wait_ent(6'h02, 32'h2000_0008, 1'b1);
    do_reset;
    chk("vtor reset", 32'h0, vtor);
  endtask

  // Main sequence
  initial begin
    do_reset;
    t_vec;
    do_reset;
    t_irq;
    do_reset;
    t_tie;
    do_reset;
    t_pre;
    do_reset;
    t_vtor;
    end_of_test;
  end
endmodule

`default_nettype wire
